// >>> src/sfe_params.svh
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH

// bit rate select encodings
`define SFE_RATE_DIVIDE_BY_TWO 2'h0
`define SFE_RATE_DIVIDE_BY_EIGHT 2'h1
`define SFE_RATE_DIVIDE_BY_THIRTY_TWO 2'h2
`define SFE_RATE_DIVIDE_BY_ONE_TWENTY_EIGHT 2'h3

// half bit time in bus cycles per divider setting
`define SFE_HALF_DIVIDE_BY_TWO 7'h01
`define SFE_HALF_DIVIDE_BY_EIGHT 7'h04
`define SFE_HALF_DIVIDE_BY_THIRTY_TWO 7'h10
`define SFE_HALF_DIVIDE_BY_ONE_TWENTY_EIGHT 7'h40
`define SFE_CNT_ONE 7'h01
`define SFE_CNT_ZERO 7'h00

// edge bookkeeping for one byte
`define SFE_EDGE_ZERO 5'h00
`define SFE_EDGE_ONE 5'h01
`define SFE_EDGE_LAST 5'h10
`define SFE_OVR_CYCLE 4'h6
`define SFE_BYTE_ZERO 8'h00
`define SFE_MSB 7

// longest wait from arming to first half bit, bus cycles
`define SFE_MAX_LATENCY 64

`endif

// >>> src/sfe_pkg.sv
package sfe_pkg;

	typedef struct packed {
		logic moduleEnable;
		logic masterSelect;
		logic clockPolarity;
		logic clockPhase;
		logic modeFaultDetectEnable;
		logic [1:0] bitRateSelect;
	} sfe_cfg_t;

	typedef struct packed {
		logic txEmptyFlag;
		logic rxFullFlag;
		logic overrunFlag;
		logic modeFaultFlag;
	} sfe_status_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h1,
		S_ARMED = 3'h2,
		S_SHIFT = 3'h4
	} sfe_state_t;

endpackage : sfe_pkg

// >>> src/sfe_rate_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfe_params.svh"

module sfe_rate_gen (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic [1:0] bitRateSelect,
	output logic tick
);
	logic [6:0] count_reg;
	logic [6:0] half;

	always_comb
	begin
		case (bitRateSelect)
			`SFE_RATE_DIVIDE_BY_TWO: half = `SFE_HALF_DIVIDE_BY_TWO;
			`SFE_RATE_DIVIDE_BY_EIGHT: half = `SFE_HALF_DIVIDE_BY_EIGHT;
			`SFE_RATE_DIVIDE_BY_THIRTY_TWO: half = `SFE_HALF_DIVIDE_BY_THIRTY_TWO;
			`SFE_RATE_DIVIDE_BY_ONE_TWENTY_EIGHT: half = `SFE_HALF_DIVIDE_BY_ONE_TWENTY_EIGHT;
			default: half = `SFE_HALF_DIVIDE_BY_TWO;
		endcase
	end

	// free-running half bit tick, stopped when disabled
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_reg <= `SFE_CNT_ZERO;
			tick <= 1'b0;
		end
		else if (!enable)
		begin
			count_reg <= `SFE_CNT_ZERO;
			tick <= 1'b0;
		end
		else if (count_reg >= half - `SFE_CNT_ONE)
		begin
			count_reg <= `SFE_CNT_ZERO;
			tick <= 1'b1;
		end
		else
		begin
			count_reg <= count_reg + `SFE_CNT_ONE;
			tick <= 1'b0;
		end
	end

	property p_tickGated;
		@(posedge mclk) disable iff (!reset_n)
		!enable |=> !tick;
	endproperty
	a_tickGated: assert property (p_tickGated) else $error("tick while disabled");

endmodule : sfe_rate_gen

`default_nettype wire

// >>> src/sfe_sticky_flag.sv
`timescale 1ns/100ps
`default_nettype none

module sfe_sticky_flag (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic setEvent,
	input wire logic armEvent,
	input wire logic clearEvent,
	input wire logic holdCondition,
	output logic flag
);
	logic armed_reg;

	// set wins over clear; clear needs a prior status read
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			flag <= 1'b0;
		else if (setEvent)
			flag <= 1'b1;
		else if (clearEvent && armed_reg && !holdCondition)
			flag <= 1'b0;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			armed_reg <= 1'b0;
		else if (armEvent && flag)
			armed_reg <= 1'b1;
		else if (clearEvent || !flag)
			armed_reg <= 1'b0;
	end

	property p_setWins;
		@(posedge mclk) disable iff (!reset_n)
		setEvent |=> flag;
	endproperty
	a_setWins: assert property (p_setWins) else $error("flag lost its set event");

endmodule : sfe_sticky_flag

`default_nettype wire

// >>> src/sfe_transfer_engine.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfe_params.svh"

module sfe_transfer_engine
	import sfe_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire sfe_pkg::sfe_cfg_t cfg,
	input wire logic dataWrite,
	input wire logic [7:0] dataWriteByte,
	input wire logic statusRead,
	input wire logic dataRead,
	input wire logic controlWrite,
	output logic [7:0] rxData,
	output wire sfe_pkg::sfe_status_t status,
	input wire logic serialClockPinIn,
	output logic serialClockPinOut,
	output logic serialClockPinOe,
	input wire logic mosiIn,
	output logic mosiOut,
	output logic mosiOe,
	input wire logic misoIn,
	output logic misoOut,
	output logic misoOe,
	input wire logic slaveSelectIn_n
);
	import sfe_pkg::*;

	localparam int LatMax = `SFE_MAX_LATENCY;

	sfe_state_t state_reg;
	logic [7:0] shift_reg;
	logic [7:0] txBuf_reg;
	logic txPending_reg;
	logic txEmpty_reg;
	logic [4:0] edgeCnt_reg;
	logic capBit_reg;
	logic sclkPrev_reg;
	logic ssPrev_reg;
	logic tick;
	logic masterOn;
	logic slaveOn;
	logic ssLow;
	logic sclkEdge;
	logic slaveStart;
	logic edgeEv;
	logic [4:0] edgeNum;
	logic leading;
	logic sampleEdge;
	logic lastEdge;
	logic inBit;
	logic done;
	logic abort;
	logic masterFault;
	logic slaveFault;
	logic loadTx;
	logic ovSet;
	logic rxLoad;
	logic [7:0] nextShift;

	sfe_rate_gen u_rate (
		.mclk(mclk),
		.reset_n(reset_n),
		.enable(masterOn),
		.bitRateSelect(cfg.bitRateSelect),
		.tick(tick)
	);

	assign masterOn = cfg.moduleEnable & cfg.masterSelect;
	assign slaveOn = cfg.moduleEnable & ~cfg.masterSelect;
	assign ssLow = ~slaveSelectIn_n;
	assign sclkEdge = serialClockPinIn ^ sclkPrev_reg;
	assign slaveStart = slaveOn && (state_reg == S_IDLE) &&
		(cfg.clockPhase ? (sclkEdge && ssLow) : (ssLow && ssPrev_reg));
	// slave ignores clocks while deselected
	assign edgeEv = ((state_reg == S_SHIFT) &&
		(cfg.masterSelect ? tick : (sclkEdge && ssLow))) ||
		(slaveStart && cfg.clockPhase);
	assign edgeNum = edgeCnt_reg + `SFE_EDGE_ONE;
	assign leading = edgeNum[0];
	assign sampleEdge = leading ^ cfg.clockPhase;
	assign lastEdge = (edgeNum == `SFE_EDGE_LAST);
	assign inBit = cfg.masterSelect ? misoIn : mosiIn;
	assign nextShift = {shift_reg[6:0], (sampleEdge ? inBit : capBit_reg)};
	assign masterFault = masterOn && cfg.modeFaultDetectEnable && ssLow;
	assign slaveFault = slaveOn && cfg.modeFaultDetectEnable &&
		(state_reg == S_SHIFT) && !ssLow;
	assign abort = !cfg.moduleEnable || masterFault ||
		(slaveOn && (state_reg == S_SHIFT) && !ssLow);
	assign done = edgeEv && lastEdge && !abort;
	assign loadTx = txPending_reg && (state_reg == S_IDLE) &&
		cfg.moduleEnable && !masterFault;
	assign ovSet = edgeEv && sampleEdge && !abort &&
		(edgeCnt_reg[4:1] == `SFE_OVR_CYCLE) && status.rxFullFlag;
	assign rxLoad = done && !status.overrunFlag;

	// transfer sequencing
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			state_reg <= S_IDLE;
		else if (abort)
			state_reg <= S_IDLE;
		else
		begin
			case (state_reg)
				S_IDLE:
				begin
					if (slaveStart)
						state_reg <= S_SHIFT;
					else if (loadTx && cfg.masterSelect)
						state_reg <= S_ARMED;
				end
				S_ARMED:
				begin
					if (tick)
						state_reg <= S_SHIFT;
				end
				S_SHIFT:
				begin
					if (done)
						state_reg <= S_IDLE;
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			edgeCnt_reg <= `SFE_EDGE_ZERO;
		else if (state_reg != S_SHIFT && !slaveStart)
			edgeCnt_reg <= `SFE_EDGE_ZERO;
		else if (edgeEv)
			edgeCnt_reg <= edgeNum;
	end

	// shift register: load when idle, shift on edges
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			shift_reg <= `SFE_BYTE_ZERO;
			capBit_reg <= 1'b0;
		end
		else if (loadTx)
			shift_reg <= txBuf_reg;
		else if (edgeEv && !abort)
		begin
			if (sampleEdge)
				capBit_reg <= inBit;
			// first edge of phase one leaves msb in place
			if (lastEdge || (!sampleEdge && edgeNum != `SFE_EDGE_ONE))
				shift_reg <= nextShift;
		end
	end

	// transmit buffer and empty flag
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			txBuf_reg <= `SFE_BYTE_ZERO;
			txPending_reg <= 1'b0;
			txEmpty_reg <= 1'b1;
		end
		else if (dataWrite)
		begin
			txBuf_reg <= dataWriteByte;
			txPending_reg <= 1'b1;
			txEmpty_reg <= 1'b0;
		end
		else if (loadTx || masterFault)
		begin
			txPending_reg <= 1'b0;
			txEmpty_reg <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			rxData <= `SFE_BYTE_ZERO;
		else if (rxLoad)
			rxData <= nextShift;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sclkPrev_reg <= 1'b0;
			ssPrev_reg <= 1'b1;
		end
		else
		begin
			sclkPrev_reg <= serialClockPinIn;
			ssPrev_reg <= slaveSelectIn_n;
		end
	end

	// master clock: idle at polarity, toggles on ticks
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			serialClockPinOut <= 1'b0;
		else if (state_reg == S_SHIFT && cfg.masterSelect && edgeEv && !abort)
			serialClockPinOut <= cfg.clockPolarity ^ leading;
		else if (state_reg != S_SHIFT || abort)
			serialClockPinOut <= cfg.clockPolarity;
	end

	// pin drivers
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			serialClockPinOe <= 1'b0;
			mosiOe <= 1'b0;
			misoOe <= 1'b0;
		end
		else
		begin
			serialClockPinOe <= masterOn && !masterFault;
			mosiOe <= masterOn && !masterFault;
			misoOe <= slaveOn && ssLow;
		end
	end

	always_comb
	begin
		mosiOut = shift_reg[`SFE_MSB];
		misoOut = shift_reg[`SFE_MSB];
	end

	sfe_sticky_flag u_rxFull (
		.mclk(mclk),
		.reset_n(reset_n),
		.setEvent(rxLoad),
		.armEvent(statusRead),
		.clearEvent(dataRead),
		.holdCondition(1'b0),
		.flag(status.rxFullFlag)
	);

	sfe_sticky_flag u_overrun (
		.mclk(mclk),
		.reset_n(reset_n),
		.setEvent(ovSet),
		.armEvent(statusRead),
		.clearEvent(dataRead),
		.holdCondition(1'b0),
		.flag(status.overrunFlag)
	);

	sfe_sticky_flag u_modeFault (
		.mclk(mclk),
		.reset_n(reset_n),
		.setEvent(masterFault || slaveFault),
		.armEvent(statusRead),
		.clearEvent(controlWrite),
		.holdCondition(masterFault || slaveFault),
		.flag(status.modeFaultFlag)
	);

	assign status.txEmptyFlag = txEmpty_reg;

	sequence s_masterIdle;
		!(state_reg == S_SHIFT) && cfg.masterSelect;
	endsequence

	property p_idleLevel;
		@(posedge mclk) disable iff (!reset_n)
		s_masterIdle ##1 (s_masterIdle && $stable(cfg.clockPolarity)) |->
			serialClockPinOut == cfg.clockPolarity;
	endproperty
	a_idleLevel: assert property (p_idleLevel) else $error("clock idle level wrong");

	property p_misoOe;
		@(posedge mclk) disable iff (!reset_n)
		(!ssLow || !slaveOn) |=> !misoOe;
	endproperty
	a_misoOe: assert property (p_misoOe) else $error("miso driven while deselected");

	property p_emptyAgain;
		@(posedge mclk) disable iff (!reset_n)
		(loadTx && !dataWrite) |-> ##[1:2] txEmpty_reg;
	endproperty
	a_emptyAgain: assert property (p_emptyAgain) else $error("tx empty not set");

	property p_writeClears;
		@(posedge mclk) disable iff (!reset_n)
		dataWrite |=> !txEmpty_reg && txBuf_reg == $past(dataWriteByte);
	endproperty
	a_writeClears: assert property (p_writeClears) else $error("write did not clear");

	property p_busyHolds;
		@(posedge mclk) disable iff (!reset_n)
		(state_reg == S_SHIFT && !done && !abort) |=> $stable(txPending_reg) || txPending_reg;
	endproperty
	a_busyHolds: assert property (p_busyHolds) else $error("buffer loaded mid byte");

	property p_overrunKeeps;
		@(posedge mclk) disable iff (!reset_n)
		(done && status.overrunFlag) |=> $stable(rxData);
	endproperty
	a_overrunKeeps: assert property (p_overrunKeeps) else $error("overrun byte stored");

	property p_rxLoads;
		@(posedge mclk) disable iff (!reset_n)
		(done && !status.overrunFlag) |=> status.rxFullFlag && rxData == $past(nextShift);
	endproperty
	a_rxLoads: assert property (p_rxLoads) else $error("rx byte not loaded");

	property p_faultSets;
		@(posedge mclk) disable iff (!reset_n)
		masterFault |=> status.modeFaultFlag && state_reg == S_IDLE;
	endproperty
	a_faultSets: assert property (p_faultSets) else $error("mode fault missed");

	property p_startLatency;
		@(posedge mclk) disable iff (!reset_n)
		$rose(state_reg == S_ARMED) |-> ##[1:LatMax] (state_reg != S_ARMED);
	endproperty
	a_startLatency: assert property (p_startLatency) else $error("start too late");

endmodule : sfe_transfer_engine

`default_nettype wire

// >>> dv/sfe_far_slave.sv
`timescale 1ns/100ps
`default_nettype none

module sfe_far_slave (
	input wire logic sclk,
	input wire logic mosi,
	input wire logic select_n,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [7:0] txByte,
	output logic miso,
	output logic [7:0] rxByte
);
	logic [7:0] shiftReg = 8'h5A;
	logic started = 1'h0;
	wire logic mosiHeld;

	// mosi as it stood just before a coincident clock edge
	assign #1 mosiHeld = mosi;

	// load at select, msb shown at once
	always @(negedge select_n)
	begin
		shiftReg = txByte;
		started = 1'h0;
	end

	// sample on one edge, shift on the other
	always @(sclk)
	begin
		if (!select_n)
		begin
			if ((sclk != cpol) == !cpha)
				rxByte = {rxByte[6:0], mosiHeld};
			else if (cpha && !started)
				started = 1'h1;
			else
				shiftReg = {shiftReg[6:0], ~shiftReg[0]};
		end
	end

	// released line shows the inverse of its last bit
	assign miso = select_n ? ~shiftReg[7] : shiftReg[7];
endmodule : sfe_far_slave
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import sfe_pkg::*;

	logic mclk = 1'h0;
	logic reset_n = 1'h0;
	sfe_cfg_t cfg = '0;
	logic dataWrite = 1'h0;
	logic [7:0] dataWriteByte = 8'h00;
	logic statusRead = 1'h0;
	logic dataRead = 1'h0;
	logic controlWrite = 1'h0;
	logic [7:0] rxData;
	sfe_status_t status;
	logic sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe, farMiso;
	logic tbSclk = 1'h0;
	logic tbMosi = 1'h0;
	logic select_n = 1'h1;
	logic farSelect_n = 1'h1;
	logic [7:0] farRx;
	logic sclkLine;
	logic mosiLine;
	int fail_count = 0;
	int num_checks = 0;

	assign sclkLine = sclkOe ? sclkOut : tbSclk;
	assign mosiLine = mosiOe ? mosiOut : tbMosi;

	always #20 mclk = ~mclk;

	sfe_transfer_engine uut (
		.mclk(mclk), .reset_n(reset_n), .cfg(cfg), .dataWrite(dataWrite),
		.dataWriteByte(dataWriteByte), .statusRead(statusRead), .dataRead(dataRead),
		.controlWrite(controlWrite), .rxData(rxData), .status(status),
		.serialClockPinIn(sclkLine), .serialClockPinOut(sclkOut), .serialClockPinOe(sclkOe),
		.mosiIn(mosiLine), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(farMiso),
		.misoOut(misoOut), .misoOe(misoOe), .slaveSelectIn_n(select_n)
	);

	sfe_far_slave far (
		.sclk(sclkLine), .mosi(mosiLine), .select_n(farSelect_n), .cpol(cfg.clockPolarity),
		.cpha(cfg.clockPhase), .txByte(8'h96), .miso(farMiso), .rxByte(farRx)
	);

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic finish_test;
		if (fail_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	task automatic pulse(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
	endtask : pulse

	task automatic write_byte(input logic [7:0] b);
		dataWriteByte = b;
		pulse(dataWrite);
	endtask : write_byte

	task automatic read_clear;
		pulse(statusRead);
		pulse(dataRead);
		cyc(1);
		check("rx full, overrun", 8'h00, {6'h00, status.rxFullFlag, status.overrunFlag});
	endtask : read_clear

	// module off around mode changes
	task automatic set_cfg(input logic m, input logic pol, input logic pha, input logic [1:0] r);
		cfg.moduleEnable = 1'h0;
		cyc(1);
		cfg.masterSelect = m;
		cfg.clockPolarity = pol;
		cfg.clockPhase = pha;
		cfg.bitRateSelect = r;
		tbSclk = pol;
		cyc(1);
		cfg.moduleEnable = 1'h1;
		cyc(3);
	endtask : set_cfg

	task automatic master_xfer(input logic [7:0] tx, input logic [7:0] q, input int half,
		input int nb);
		int n;
		int t;
		logic last;
		n = 0;
		last = sclkLine;
		farSelect_n = 1'h0;
		check("clock idle", 8'(cfg.clockPolarity), 8'(sclkLine));
		write_byte(tx);
		check("tx empty low", 8'h00, 8'(status.txEmptyFlag));
		cyc(2);
		check("tx empty again", 8'h01, 8'(status.txEmptyFlag));
		t = 3;
		if (nb == 2)
			write_byte(q);
		for (int c = 0; c < 3000 && n < 16 * nb; c++)
		begin
			cyc(1);
			t++;
			if (sclkLine !== last)
			begin
				n++;
				last = sclkLine;
				if (n == 1 || n == 17)
					check("start delay", 8'h01, 8'(t <= 2 * half + 4));
				if (n == 2)
					check("half bit", 8'(half), 8'(t));
				t = 0;
			end
		end
		if (n < 16 * nb)
		begin
			fail_count++;
			finish_test();
		end
		cyc(2);
		check("far side byte", nb == 2 ? q : tx, farRx);
		check("clock back idle", 8'(cfg.clockPolarity), 8'(sclkLine));
		farSelect_n = 1'h1;
		cyc(1);
	endtask : master_xfer

	task automatic t_modes;
		for (int m = 0; m < 4; m++)
		begin
			set_cfg(1'h1, m[1], m[0], 2'h0);
			master_xfer(8'hC5 ^ 8'(m), 8'h00, 1, 1);
			check("rx byte", 8'h96, rxData);
			check("rx full", 8'h01, 8'(status.rxFullFlag));
			read_clear();
		end
	endtask : t_modes

	task automatic t_rates;
		for (int r = 0; r < 4; r++)
		begin
			set_cfg(1'h1, 1'h0, 1'h0, 2'(r));
			master_xfer(8'h5A, 8'h00, 1 << (2 * r), 1);
			read_clear();
		end
	endtask : t_rates

	task automatic t_queue;
		set_cfg(1'h1, 1'h0, 1'h1, 2'h1);
		master_xfer(8'h81, 8'h7E, 4, 2);
		check("overrun", 8'h01, 8'(status.overrunFlag));
		check("old byte kept", 8'h96, rxData);
		read_clear();
	endtask : t_queue

	task automatic t_fault;
		cfg.modeFaultDetectEnable = 1'h1;
		select_n = 1'h0;
		cyc(4);
		check("fault", 8'h01, 8'(status.modeFaultFlag));
		check("clock released", 8'h00, 8'(sclkOe));
		select_n = 1'h1;
		cyc(2);
		pulse(controlWrite);
		cyc(1);
		check("fault kept", 8'h01, 8'(status.modeFaultFlag));
		pulse(statusRead);
		pulse(controlWrite);
		cyc(1);
		check("fault cleared", 8'h00, 8'(status.modeFaultFlag));
	endtask : t_fault

	task automatic slave_byte(input logic [7:0] ex, input logic [7:0] in, input logic [7:0] mid);
		select_n = 1'h0;
		cyc(2);
		check("miso driven", 8'h01, 8'(misoOe));
		for (int i = 7; i >= 0; i--)
		begin
			if (!cfg.clockPhase)
				check("miso bit", 8'(ex[i]), 8'(misoOut));
			tbMosi = in[i];
			cyc(2);
			tbSclk = ~cfg.clockPolarity;
			cyc(2);
			if (cfg.clockPhase)
				check("miso bit", 8'(ex[i]), 8'(misoOut));
			if (i == 6 && mid != 8'h00)
				write_byte(mid);
			if (i == 0 && mid != 8'h00)
				check("tx waits", 8'h00, 8'(status.txEmptyFlag));
			cyc(2);
			tbSclk = cfg.clockPolarity;
			cyc(2);
		end
		cyc(2);
		check("slave rx", in, rxData);
		check("tx empty", 8'h01, 8'(status.txEmptyFlag));
		select_n = 1'h1;
		cyc(2);
		check("miso released", 8'h00, 8'(misoOe));
		read_clear();
	endtask : slave_byte

	task automatic t_slave;
		set_cfg(1'h0, 1'h0, 1'h0, 2'h0);
		write_byte(8'hA5);
		cyc(2);
		check("unselected quiet", 8'h00, 8'(misoOe));
		slave_byte(8'hA5, 8'h3C, 8'h0F);
		slave_byte(8'h0F, 8'hE1, 8'h00);
		set_cfg(1'h0, 1'h1, 1'h1, 2'h0);
		write_byte(8'hC3);
		cyc(2);
		slave_byte(8'hC3, 8'h5A, 8'h00);
	endtask : t_slave

	initial
	begin
		cyc(3);
		check("status at reset", 8'h08, 8'(status));
		check("drivers off", 8'h00, {5'h00, sclkOe, mosiOe, misoOe});
		cyc(1);
		reset_n = 1'h1;
		cyc(2);
		t_modes();
		t_rates();
		t_queue();
		t_fault();
		t_slave();
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
